// ### core/fir_port_defs.svh
/*
  Constants for the FIR filter port interface: widths, counts, limits.
  Assumes inclusion by bare name from package and design files.
*/
`ifndef FIR_PORT_DEFS_SVH
`define FIR_PORT_DEFS_SVH

`define FIR_DATA_WIDTH      16
`define FIR_COEF_WIDTH      16
`define FIR_OUT_WIDTH       16
`define FIR_TAPS            8
`define FIR_CHANNELS        2
`define FIR_MAX_RATIO       4
`define FIR_RATIO_SETTLE    4
`define FIR_SIGNED          1
`define FIR_SYMMETRIC       0
`define FIR_INTERP          0
`define FIR_TAP_INDEX_W     4

`endif

// ### core/fir_port_pkg.sv
/*
  Types shared by both ends of the FIR filter port interface.
  Assumes fir_port_defs.svh is on the include path.
*/
`include "fir_port_defs.svh"
package fir_port_pkg;

	// Core operating phases
	typedef enum logic [1:0]
	{
		LOADING,
		RUNNING,
		SETTLING
	} core_state_type;

	// Source sequencing phases
	typedef enum logic [1:0]
	{
		SRC_IDLE,
		SRC_LOAD,
		SRC_COMMIT,
		SRC_STREAM
	} source_state_type;

	// Weight bus width from coefficient width and options
	function automatic int weight_width(input int cw, input int sgn,
		input int sym, input int interp);
		if (sym != 0 && interp != 0)
			return (sgn != 0) ? cw + 1 : cw + 2;
		return cw;
	endfunction

	// Ratio port width: ceil(log2(max ratio + 1))
	function automatic int ratio_width(input int maxr);
		return $clog2(maxr + 1);
	endfunction

endpackage

// ### core/fir_port_if.sv
/*
  Interface joining the upstream source/consumer and the FIR core.
  Assumes both ends share one clock and reset from the bench.
*/
`include "fir_port_defs.svh"
interface fir_port_if
#(
	parameter int DW = `FIR_DATA_WIDTH,
	parameter int OW = `FIR_OUT_WIDTH,
	parameter int WW = fir_port_pkg::weight_width(`FIR_COEF_WIDTH,
		`FIR_SIGNED, `FIR_SYMMETRIC, `FIR_INTERP),
	parameter int RW = fir_port_pkg::ratio_width(`FIR_MAX_RATIO)
);
	logic [DW-1:0] sample;
	logic          sample_valid;
	logic          in_block_start;
	logic          ready_for_input;
	logic [OW-1:0] result;
	logic          result_valid;
	logic          out_block_start;
	logic [WW-1:0] weight;
	logic          weight_we;
	logic          weight_commit;
	logic [RW-1:0] ratio;
	logic          ratio_load;
	logic          enable;
	logic          sync_clear;

	modport core
	(
		input  sample, sample_valid, in_block_start, weight, weight_we,
		input  weight_commit, ratio, ratio_load, enable, sync_clear,
		output ready_for_input, result, result_valid, out_block_start
	);
	modport source
	(
		output sample, sample_valid, in_block_start, weight, weight_we,
		output weight_commit, ratio, ratio_load, enable, sync_clear,
		input  ready_for_input, result, result_valid, out_block_start
	);
endinterface

// ### core/fir_mac.sv
/*
  Direct-form multiply-accumulate over a tap delay line for one channel
  slot. Assumes caller qualifies shift with enable and clear.
*/
`include "fir_port_defs.svh"
module fir_mac
#(
	parameter int DW   = `FIR_DATA_WIDTH,
	parameter int WW   = `FIR_COEF_WIDTH,
	parameter int OW   = `FIR_OUT_WIDTH,
	parameter int TAPS = `FIR_TAPS
)
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 clear,
	input  wire logic                 shift,
	input  wire logic [DW-1:0]        sample,
	input  wire logic [TAPS*WW-1:0]   weights,
	output      logic [OW-1:0]        sum
);
	logic signed [DW-1:0] taps [TAPS];
	logic signed [DW+WW+7:0] products [TAPS];
	logic signed [DW+WW+7:0] acc;

	// Accumulator has eight guard bits, so at most 256 taps
	generate
		if (TAPS < 1 || TAPS > 256 || DW < 1 || WW < 1)
		begin : gen_bad_params
			$error("fir_mac: unsupported parameters");
		end
	endgenerate

	// Tap delay line; moves only on accepted samples
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			for (int i = 0; i < TAPS; i++) taps[i] <= '0;
		else if (clear)
			for (int i = 0; i < TAPS; i++) taps[i] <= '0;
		else if (shift)
		begin
			taps[0] <= sample;
			for (int i = 1; i < TAPS; i++) taps[i] <= taps[i-1];
		end
	end

	// Products per tap, summed combinationally
	genvar g;
	generate
		for (g = 0; g < TAPS; g++)
		begin : gen_prod
			assign products[g] = (DW+WW+8)'(taps[g]
				* $signed(weights[g*WW +: WW]));
		end
	endgenerate

	always_comb
	begin
		acc = '0;
		for (int i = 0; i < TAPS; i++) acc = acc + products[i];
	end

	// Keep the top result bits; no rounding
	assign sum = acc[DW+WW-1 -: OW];
endmodule

// ### core/fir_core.sv
/*
  Documented FIR filter core end: sample handshake, weight reload with
  commit, channel block start, run-time ratio, enable and sync clear.
  Assumes source end keeps its own sequencing; one clock, async reset.
*/
// Functional notes
// - All ports synchronous to one clock
// - Reset acts asynchronously on whole core
// - Capture sample only when valid high
// - Result meaningful only when valid flag high
// - Ready high whenever next sample acceptable
// - Source sends only after ready prior cycle
// - Weight write each cycle enable asserted
// - Source loads weights in required order
// - Source pulses commit one cycle after loading
// - Commit switches to newly loaded weight set
// - Weight width depends on symmetry and sign
// - Source flags channel 0 with block start
// - Output block start marks channel 0
// - Ratio load strobe adopts new ratio value
// - Enable low freezes all state, ignores inputs
// - Sync clear returns registers to reset
// - Source holds write enable through whole load
// - Ready low until weights loaded and committed
// - Ratio change drops ready several cycles
// - Block start coincides with channel 0 result
`include "fir_port_defs.svh"
module fir_core
#(
	parameter int DW       = `FIR_DATA_WIDTH,
	parameter int CW       = `FIR_COEF_WIDTH,
	parameter int OW       = `FIR_OUT_WIDTH,
	parameter int TAPS     = `FIR_TAPS,
	parameter int CHANNELS = `FIR_CHANNELS,
	parameter int MAXR     = `FIR_MAX_RATIO,
	parameter int SETTLE   = `FIR_RATIO_SETTLE,
	parameter int SGN      = `FIR_SIGNED,
	parameter int SYM      = `FIR_SYMMETRIC,
	parameter int INTERP   = `FIR_INTERP,
	parameter int WW       = fir_port_pkg::weight_width(CW, SGN, SYM,
		INTERP),
	parameter int RW       = fir_port_pkg::ratio_width(MAXR)
)
(
	input  wire logic REF_CLK,
	input  wire logic RESET,
	fir_port_if.core  PORT,
	output      logic [RW-1:0] RATIO,
	output      logic          WEIGHTS_LIVE
);
	localparam int TW = `FIR_TAP_INDEX_W;
	localparam int CHW = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;

	// Elaboration check: load index and settle counter widths limit these
	generate
		if (TAPS < 1 || TAPS >= (1 << TW) || CHANNELS < 1 || MAXR < 2
			|| SETTLE < 1 || SETTLE > 255 || WW < CW)
		begin : gen_bad_params
			$error("fir_core: unsupported parameters");
		end
	endgenerate

	fir_port_pkg::core_state_type state;
	fir_port_pkg::core_state_type next_state;
	logic [TAPS*WW-1:0] shadow;
	logic [TAPS*WW-1:0] active;
	logic [TW-1:0]      load_index;
	logic [7:0]         settle_count;
	logic [CHW-1:0]     channel;
	logic [OW-1:0]      mac_sum [CHANNELS];
	logic [CHANNELS-1:0] shift;

	// Enable gates every update; clear wins over everything else
	wire run = PORT.enable;
	wire clr = run && PORT.sync_clear;
	wire take = run && !clr && state == fir_port_pkg::RUNNING
		&& PORT.ready_for_input && PORT.sample_valid;
	wire write_w = run && !clr && PORT.weight_we;
	wire commit = run && !clr && PORT.weight_commit;
	wire ratio_ok = PORT.ratio >= RW'(2) && PORT.ratio <= RW'(MAXR);
	wire new_ratio = run && !clr && PORT.ratio_load && ratio_ok
		&& PORT.ratio != RATIO;
	// Channel slot of the sample now taken; block start realigns
	wire [CHW-1:0] slot = (CHANNELS > 1 && PORT.in_block_start)
		? '0 : channel;
	wire [CHW-1:0] slot_next = (slot == CHW'(CHANNELS - 1))
		? '0 : CHW'(slot + 1'b1);

	// Operating phase: loading, running, or settling after a ratio change
	always_comb
	begin
		next_state = state;
		unique case (state)
			fir_port_pkg::LOADING:
				if (commit) next_state = fir_port_pkg::RUNNING;
			fir_port_pkg::RUNNING:
				if (new_ratio) next_state = fir_port_pkg::SETTLING;
			fir_port_pkg::SETTLING:
				if (settle_count == 8'h00)
					next_state = fir_port_pkg::RUNNING;
		endcase
		if (commit && state == fir_port_pkg::LOADING)
			next_state = fir_port_pkg::RUNNING;
	end

	// Phase register; reset is asynchronous across the core
	always_ff @(posedge REF_CLK or posedge RESET)
	begin
		if (RESET)
			state <= fir_port_pkg::LOADING;
		else if (clr)
			state <= fir_port_pkg::LOADING;
		else if (run)
			state <= next_state;
	end

	// Weight shadow fills in arrival order, commit copies it live
	always_ff @(posedge REF_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			shadow <= '0;
			active <= '0;
			load_index <= '0;
			WEIGHTS_LIVE <= 1'b0;
		end
		else if (clr)
		begin
			shadow <= '0;
			active <= '0;
			load_index <= '0;
			WEIGHTS_LIVE <= 1'b0;
		end
		else
		begin
			if (write_w && load_index < TW'(TAPS))
			begin
				shadow[load_index*WW +: WW] <= PORT.weight;
				load_index <= TW'(load_index + 1'b1);
			end
			if (commit)
			begin
				active <= shadow;
				load_index <= '0;
				WEIGHTS_LIVE <= 1'b1;
			end
		end
	end

	// Ratio register and settle countdown
	always_ff @(posedge REF_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			RATIO <= RW'(MAXR);
			settle_count <= 8'h00;
		end
		else if (clr)
		begin
			RATIO <= RW'(MAXR);
			settle_count <= 8'h00;
		end
		else if (run)
		begin
			if (new_ratio && state == fir_port_pkg::RUNNING)
			begin
				RATIO <= PORT.ratio;
				settle_count <= 8'(SETTLE - 1);
			end
			else if (settle_count != 8'h00)
				settle_count <= settle_count - 8'h01;
		end
	end

	// One tap line per channel slot
	genvar c;
	generate
		for (c = 0; c < CHANNELS; c++)
		begin : gen_chan
			assign shift[c] = take && slot == CHW'(c);
			fir_mac #(.DW(DW), .WW(WW), .OW(OW), .TAPS(TAPS)) i_fir_mac
			(
				.clk     (REF_CLK),
				.rst     (RESET),
				.clear   (clr),
				.shift   (shift[c]),
				.sample  (PORT.sample),
				.weights (active),
				.sum     (mac_sum[c])
			);
		end
	endgenerate

	// Result stage: one result per accepted sample, one cycle later
	always_ff @(posedge REF_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			channel <= '0;
			PORT.result_valid <= 1'b0;
			PORT.out_block_start <= 1'b0;
			PORT.ready_for_input <= 1'b0;
		end
		else if (clr)
		begin
			channel <= '0;
			PORT.result_valid <= 1'b0;
			PORT.out_block_start <= 1'b0;
			PORT.ready_for_input <= 1'b0;
		end
		else if (run)
		begin
			if (take)
				channel <= slot_next;
			// Sum uses taps after this shift, so show it the cycle after
			PORT.result_valid <= 1'b0;
			PORT.out_block_start <= 1'b0;
			if (take)
			begin
				PORT.result_valid <= 1'b1;
				PORT.out_block_start <= (CHANNELS > 1)
					&& slot == '0;
			end
			PORT.ready_for_input <= next_state == fir_port_pkg::RUNNING
				&& !new_ratio;
		end
	end

	// Result bus shows the slot just shifted; slot latched with the shift, sum read combinationally
	logic [CHW-1:0] last_slot;
	always_ff @(posedge REF_CLK or posedge RESET)
	begin
		if (RESET)
			last_slot <= '0;
		else if (clr)
			last_slot <= '0;
		else if (run && take)
			last_slot <= slot;
	end
	assign PORT.result = PORT.result_valid ? mac_sum[last_slot] : '0;
endmodule

// ### core/fir_source.sv
/*
  Far end: loads a weight set, commits it, then streams samples from
  the user side under the ready handshake and returns results.
  Assumes the core end is fir_core on the same clock.
*/
`include "fir_port_defs.svh"
module fir_source
#(
	parameter int DW   = `FIR_DATA_WIDTH,
	parameter int OW   = `FIR_OUT_WIDTH,
	parameter int TAPS = `FIR_TAPS,
	parameter int CHANNELS = `FIR_CHANNELS,
	parameter int WW   = fir_port_pkg::weight_width(`FIR_COEF_WIDTH,
		`FIR_SIGNED, `FIR_SYMMETRIC, `FIR_INTERP),
	parameter int RW   = fir_port_pkg::ratio_width(`FIR_MAX_RATIO)
)
(
	input  wire logic           REF_CLK,
	input  wire logic           RESET,
	fir_port_if.source          PORT,
	input  wire logic           LOAD_START,
	input  wire logic [WW-1:0]  LOAD_WEIGHT,
	output      logic           LOAD_TAKE,
	input  wire logic [DW-1:0]  USER_SAMPLE,
	input  wire logic           USER_VALID,
	input  wire logic           USER_FIRST,
	output      logic           USER_TAKE,
	input  wire logic [RW-1:0]  USER_RATIO,
	input  wire logic           USER_RATIO_LOAD,
	input  wire logic           USER_ENABLE,
	input  wire logic           USER_CLEAR,
	output      logic [OW-1:0]  RESULT,
	output      logic           RESULT_VALID,
	output      logic           RESULT_FIRST
);
	localparam int CNTW = $clog2(TAPS + 1);

	fir_port_pkg::source_state_type state;
	logic [CNTW-1:0] count;

	// Sample allowed only after ready seen high the cycle before
	wire send_ok = state == fir_port_pkg::SRC_STREAM
		&& PORT.ready_for_input && USER_VALID;
	wire last_w = count == CNTW'(TAPS - 1);

	// Load, commit, stream sequencing
	always_ff @(posedge REF_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			state <= fir_port_pkg::SRC_IDLE;
			count <= '0;
		end
		else
		begin
			unique case (state)
				fir_port_pkg::SRC_IDLE:
					if (LOAD_START)
						state <= fir_port_pkg::SRC_LOAD;
				fir_port_pkg::SRC_LOAD:
				begin
					count <= CNTW'(count + 1'b1);
					if (last_w)
						state <= fir_port_pkg::SRC_COMMIT;
				end
				fir_port_pkg::SRC_COMMIT:
				begin
					count <= '0;
					state <= fir_port_pkg::SRC_STREAM;
				end
				fir_port_pkg::SRC_STREAM:
					if (LOAD_START)
						state <= fir_port_pkg::SRC_LOAD;
			endcase
		end
	end

	// Port drive, all registered
	always_ff @(posedge REF_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			PORT.weight <= '0;
			PORT.weight_we <= 1'b0;
			PORT.weight_commit <= 1'b0;
			PORT.sample <= '0;
			PORT.sample_valid <= 1'b0;
			PORT.in_block_start <= 1'b0;
			PORT.ratio <= '0;
			PORT.ratio_load <= 1'b0;
			PORT.enable <= 1'b0;
			PORT.sync_clear <= 1'b0;
		end
		else
		begin
			// Write enable stays high over the whole batch, in order
			PORT.weight_we <= state == fir_port_pkg::SRC_LOAD;
			PORT.weight <= LOAD_WEIGHT;
			// Commit follows the last word, never shares its cycle
			PORT.weight_commit <= state == fir_port_pkg::SRC_COMMIT;
			PORT.sample_valid <= send_ok;
			PORT.sample <= USER_SAMPLE;
			PORT.in_block_start <= send_ok && USER_FIRST
				&& CHANNELS > 1;
			PORT.ratio <= USER_RATIO;
			PORT.ratio_load <= USER_RATIO_LOAD;
			PORT.enable <= USER_ENABLE;
			PORT.sync_clear <= USER_CLEAR;
		end
	end

	// User side handshakes and result capture
	always_ff @(posedge REF_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			LOAD_TAKE <= 1'b0;
			USER_TAKE <= 1'b0;
			RESULT <= '0;
			RESULT_VALID <= 1'b0;
			RESULT_FIRST <= 1'b0;
		end
		else
		begin
			LOAD_TAKE <= state == fir_port_pkg::SRC_LOAD;
			USER_TAKE <= send_ok;
			RESULT <= PORT.result;
			RESULT_VALID <= PORT.result_valid;
			RESULT_FIRST <= PORT.out_block_start;
		end
	end
endmodule

// ### tb/fir_port_chk.sv
/*
  Checker watching the shared FIR port between source and core.
  Assumes the bench wires interface signals, clock and reset by name.
*/
module fir_port_chk
#(
	parameter int OW = 16
)
(
	input wire logic          REF_CLK,
	input wire logic          RESET,
	input wire logic          sample_valid,
	input wire logic          in_block_start,
	input wire logic          ready_for_input,
	input wire logic [OW-1:0] result,
	input wire logic          result_valid,
	input wire logic          out_block_start,
	input wire logic          weight_we,
	input wire logic          weight_commit,
	input wire logic          enable,
	input wire logic          sync_clear
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RESET);

	logic committed;
	logic take;

	// A sample is taken only with enable, ready and valid together
	assign take = enable && ready_for_input && sample_valid && !sync_clear;

	// Set by a commit, cleared by a clear; ready must wait for it
	always_ff @(posedge REF_CLK or posedge RESET)
		if (RESET)
			committed <= 1'b0;
		else if (enable && sync_clear)
			committed <= 1'b0;
		else if (enable && weight_commit)
			committed <= 1'b1;

	chk_take_answer: assert property (take |=> result_valid)
		else $error("accepted sample gave no result");
	chk_no_spurious: assert property (result_valid && $past(enable)
		|-> $past(ready_for_input && sample_valid))
		else $error("result without an accepted sample");
	chk_idle_zero: assert property (!result_valid |-> result == '0)
		else $error("result bus busy while not valid");
	chk_start_valid: assert property (out_block_start |-> result_valid)
		else $error("block start without a result");
	chk_slot_zero: assert property (take && in_block_start
		|=> out_block_start)
		else $error("channel 0 result not marked");
	chk_ready_held: assert property (!committed |-> !ready_for_input)
		else $error("ready before weights committed");
	chk_commit_ready: assert property (enable && weight_commit
		&& !sync_clear |=> ready_for_input)
		else $error("commit did not raise ready");
	chk_freeze_state: assert property (!enable
		|=> $stable(ready_for_input)
		&& $stable(result_valid) && $stable(out_block_start))
		else $error("state moved while disabled");
	chk_clear_state: assert property (enable && sync_clear
		|=> !ready_for_input && !result_valid)
		else $error("clear left state behind");
	chk_send_gated: assert property (sample_valid
		|-> $past(ready_for_input))
		else $error("sample sent without prior ready");
	chk_first_qual: assert property (in_block_start |-> sample_valid)
		else $error("block start without a sample");
	chk_commit_pulse: assert property (weight_commit |=> !weight_commit)
		else $error("commit longer than one cycle");
	chk_we_batch: assert property ($fell(weight_we) |-> weight_commit)
		else $error("write enable dropped without commit");
endmodule

// ### tb/fir_filter_port_interface_bench.sv
/*
  Bench joining source and core through the port interface.
  Assumes the core files and the checker are compiled before it.
*/
module fir_filter_port_interface_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        load_start = 1'b0;
	logic [15:0] load_weight = 16'h0000;
	logic [15:0] user_sample = 16'h0000;
	logic        user_valid = 1'b0;
	logic        user_first = 1'b0;
	logic [2:0]  user_ratio = 3'h4;
	logic        user_ratio_load = 1'b0;
	logic        user_enable = 1'b1;
	logic        user_clear = 1'b0;
	logic        load_take, user_take, result_valid, result_first, live;
	logic [15:0] result;
	logic [2:0]  ratio;
	int          failures = 0;
	int          checks_done = 0;
	int          cycles = 0;
	int          n_valid, n_start, n_nonzero, n_we, n_commit, n_low;
	int          n_take, n_rvalid, n_rfirst;
	logic [15:0] last_result = 16'h0000;

	always #12.5 ref_clk = ~ref_clk;

	fir_port_if i_fir_port_if ();

	fir_core i_fir_core (.REF_CLK(ref_clk), .RESET(reset),
		.PORT(i_fir_port_if), .RATIO(ratio), .WEIGHTS_LIVE(live));

	fir_source i_fir_source (.REF_CLK(ref_clk), .RESET(reset),
		.PORT(i_fir_port_if), .LOAD_START(load_start),
		.LOAD_WEIGHT(load_weight), .LOAD_TAKE(load_take),
		.USER_SAMPLE(user_sample), .USER_VALID(user_valid),
		.USER_FIRST(user_first), .USER_TAKE(user_take),
		.USER_RATIO(user_ratio), .USER_RATIO_LOAD(user_ratio_load),
		.USER_ENABLE(user_enable), .USER_CLEAR(user_clear),
		.RESULT(result), .RESULT_VALID(result_valid),
		.RESULT_FIRST(result_first));

	fir_port_chk i_fir_port_chk (.REF_CLK(ref_clk), .RESET(reset),
		.sample_valid(i_fir_port_if.sample_valid),
		.in_block_start(i_fir_port_if.in_block_start),
		.ready_for_input(i_fir_port_if.ready_for_input),
		.result(i_fir_port_if.result),
		.result_valid(i_fir_port_if.result_valid),
		.out_block_start(i_fir_port_if.out_block_start),
		.weight_we(i_fir_port_if.weight_we),
		.weight_commit(i_fir_port_if.weight_commit),
		.enable(i_fir_port_if.enable),
		.sync_clear(i_fir_port_if.sync_clear));

	task automatic check(input logic [31:0] seen, input logic [31:0] want,
		input string what);
		checks_done++;
		if (seen !== want)
		begin
			failures++;
			$display("unexpected at %0t: %s got %0h", $time, what, seen);
		end
	endtask

	task automatic results;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Wire counters, sampled at the edge the core sees; cut a hang short
	always @(posedge ref_clk)
	begin
		cycles++;
		n_valid += (i_fir_port_if.result_valid === 1'b1);
		n_start += (i_fir_port_if.out_block_start === 1'b1);
		n_nonzero += (i_fir_port_if.result_valid === 1'b1
			&& i_fir_port_if.result !== 16'h0000);
		n_we += (i_fir_port_if.weight_we === 1'b1);
		n_commit += (i_fir_port_if.weight_commit === 1'b1);
		n_low += (i_fir_port_if.ready_for_input !== 1'b1);
		n_take += (load_take === 1'b1);
		n_rvalid += (result_valid === 1'b1);
		n_rfirst += (result_first === 1'b1);
		if (result_valid === 1'b1)
			last_result = result;
		// Ceiling far above the roughly 120 cycles the tests need
		if (cycles == 3000)
		begin
			failures++;
			results();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic zero_counts;
		{n_valid, n_start, n_nonzero, n_we, n_commit, n_low, n_take,
			n_rvalid, n_rfirst} = '0;
	endtask

	// Loads one weight value into every tap; order cannot matter then
	task automatic load(input logic [15:0] w);
		int i;
		zero_counts();
		load_weight = w;
		// One-cycle start, else the source would begin a second load
		load_start = 1'b1;
		tick(1);
		load_start = 1'b0;
		for (i = 0; i < 100 && i_fir_port_if.ready_for_input !== 1'b1; i++)
			tick(1);
		check(n_we, 8, "write cycles");
		check(n_take, 8, "weights taken");
		check(n_commit, 1, "commits");
		check(live, 1'b1, "weights live");
	endtask

	// Back-to-back samples; valid held up between them
	task automatic burst(input logic [15:0] s, input int n);
		int i, k;
		zero_counts();
		for (k = 0; k < n; k++)
		begin
			user_sample = s;
			user_valid = 1'b1;
			user_first = (k == 0);
			i = 0;
			do
			begin
				tick(1);
				i++;
			end while (user_take !== 1'b1 && i < 50);
		end
		user_valid = 1'b0;
		user_first = 1'b0;
		tick(5);
	endtask

	task automatic set_ratio(input logic [2:0] r);
		user_ratio = r;
		user_ratio_load = 1'b1;
		tick(1);
		user_ratio_load = 1'b0;
		tick(15);
	endtask

	initial
	begin
		tick(20);
		check(i_fir_port_if.result_valid, 1'b0, "valid in reset");
		check(i_fir_port_if.out_block_start, 1'b0, "start in reset");
		check(ratio, 3'h4, "ratio in reset");
		reset = 1'b0;
		load(16'h0000);
		burst(16'h7FFF, 4);
		check(n_valid, 4, "results");
		check(n_start, 2, "block starts");
		check(n_nonzero, 0, "zero weight sums");
		check(n_rvalid, 4, "user results");
		check(n_rfirst, 2, "user block starts");
		$display("zero weight stream done");
		// Reset mid-cycle, away from any edge
		#5 reset = 1'b1;
		#1 check(i_fir_port_if.ready_for_input, 1'b0, "async ready");
		check(live, 1'b0, "async weights");
		tick(2);
		reset = 1'b0;
		load(16'h7FFF);
		burst(16'h7FFF, 1);
		check(n_nonzero, 1, "new weight sum");
		check(last_result, 16'h3FFF, "reload sum value");
		check(n_start, 1, "channel 0 mark");
		$display("reload stream done");
		zero_counts();
		set_ratio(3'h2);
		check(ratio, 3'h2, "ratio adopted");
		check(n_low > 0, 1'b1, "ready dropped");
		check(i_fir_port_if.ready_for_input, 1'b1, "ready back");
		set_ratio(3'h1);
		check(ratio, 3'h2, "ratio below range");
		$display("ratio change done");
		user_enable = 1'b0;
		tick(3);
		zero_counts();
		set_ratio(3'h3);
		check(ratio, 3'h2, "ratio while frozen");
		check(n_low, 0, "ready while frozen");
		user_enable = 1'b1;
		tick(3);
		user_clear = 1'b1;
		tick(2);
		user_clear = 1'b0;
		tick(3);
		check(i_fir_port_if.ready_for_input, 1'b0, "ready cleared");
		check(ratio, 3'h4, "ratio cleared");
		$display("freeze and clear done");
		results();
	end
endmodule
